// ### hw/sync_serial_slave_channel.sv
// clocked serial slave channel with avalon register access
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module sync_serial_slave_channel (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// avalon-mm slave
	input wire sync_serial_slave_pkg::avl_req_t i_avl,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// port one pins
	input wire logic [7:0] i_pin,
	output logic [7:0] o_pin,
	output logic [7:0] o_pin_oe,
	// interrupt
	output logic o_irq
);
	import sync_serial_slave_pkg::*;

	logic [15:0] mode_q, config_q, levels_q, enables_q, data_q;
	logic [7:0] latch_q, dir_q, mask_q, tx_buf_q, sh_q;
	logic tx_full_q, irq_flag_q, overrun_q, enabled_q, done_q, empty_ev_q;
	logic [3:0] cnt_q;
	logic [7:0] pin_s1_q, pin_s2_q;
	logic clk_d1_q;
	logic ack_q;
	chan_state_t st_q;

	// frame bits for a length code; only 7 and 8 are legal here
	function automatic logic [3:0] frame_bits(input logic [1:0] code);
		frame_bits = (code == LEN_7BIT) ? BITS_7 : BITS_8;
	endfunction

	function automatic logic len_ok(input logic [1:0] code);
		len_ok = (code == LEN_7BIT) || (code == LEN_8BIT);
	endfunction

	// the data word and its byte view share one storage
	function automatic logic data_view(input logic [3:0] a);
		data_view = (a == REG_DATA) || (a == REG_BYTE_VIEW);
	endfunction

	// two-flop synchronisers for all pins, link clock included;
	// the clock bit resets to its idle high so no false edge follows reset
	localparam logic [7:0] PIN_SYNC_RST = 8'h01 << PIN_CLK;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_s1_q <= PIN_SYNC_RST;
			pin_s2_q <= PIN_SYNC_RST;
		end else begin
			pin_s1_q <= i_pin;
			pin_s2_q <= pin_s1_q;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_d1_q <= 1'b1;
		end else begin
			clk_d1_q <= pin_s2_q[PIN_CLK];
		end
	end

	// shift-clock rising edge; clock idles high, the next bit leaves
	// right after a rise, well before the master samples again
	logic ext_clk, sck_rise, lsb_first, acc, wr, rd, last_bit;
	logic [3:0] nbits;
	assign ext_clk = mode_q[MODE_CLK_SEL_BIT];
	assign sck_rise = ext_clk && !clk_d1_q && pin_s2_q[PIN_CLK];
	assign lsb_first = config_q[CFG_BIT_ORDER_BIT];
	assign nbits = frame_bits(config_q[1:0]);
	assign last_bit = (cnt_q == nbits - 4'h1);
	assign acc = (i_avl.read || i_avl.write) && !ack_q;
	// writes land on the edge that ends the wait, the one the master sees
	assign wr = ack_q && i_avl.write;
	assign rd = acc && i_avl.read;

	// one wait cycle per access, answer on the second edge
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_waitrequest <= 1'b1;
		end else begin
			o_waitrequest <= !acc;
		end
	end

	// software configuration registers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q <= MODE_RST;
			config_q <= CONFIG_RST;
			levels_q <= OUT_LEVELS_RST;
			enables_q <= OUT_ENABLES_RST;
			latch_q <= PORT_LATCH_RST;
			dir_q <= PORT_DIR_RST;
			mask_q <= IRQ_MASK_RST;
		end else if (wr && i_avl.byteenable[0]) begin
			unique case (i_avl.address)
				REG_MODE: mode_q <= i_avl.writedata[15:0];
				REG_CONFIG: config_q <= i_avl.writedata[15:0];
				REG_OUT_LEVELS: levels_q <= i_avl.writedata[15:0];
				REG_OUT_ENABLES: enables_q <= i_avl.writedata[15:0];
				REG_PORT_LATCH: latch_q <= i_avl.writedata[7:0];
				REG_PORT_DIR: dir_q <= i_avl.writedata[7:0];
				REG_IRQ_MASKS: mask_q <= i_avl.writedata[7:0];
				default: ;
			endcase
		end
	end

	// transmit buffer loaded by data or byte-view writes
	logic tx_wr, take_buf;
	assign tx_wr = wr && i_avl.byteenable[0] && data_view(i_avl.address);
	assign take_buf = (st_q == ST_WAIT) && tx_full_q && len_ok(config_q[1:0]);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_buf_q <= 8'h00;
			tx_full_q <= 1'b0;
		end else if (tx_wr) begin
			tx_buf_q <= i_avl.writedata[7:0];
			tx_full_q <= 1'b1;
		end else if (take_buf) begin
			tx_full_q <= 1'b0;
		end
	end

	// channel enable: start sets, stop clears
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			enabled_q <= 1'b0;
		end else if (wr && i_avl.address == REG_START && i_avl.writedata[CHAN_BIT]) begin
			enabled_q <= 1'b1;
		end else if (wr && i_avl.address == REG_STOP && i_avl.writedata[CHAN_BIT]) begin
			enabled_q <= 1'b0;
		end
	end

	// engine: idle, waiting for data, shifting
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (st_q)
				ST_IDLE: begin
					if (enabled_q && len_ok(config_q[1:0])) begin
						st_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (!enabled_q) begin
						st_q <= ST_IDLE;
					end else if (take_buf) begin
						// msb first aligns to frame top
						sh_q <= (lsb_first || nbits == BITS_8) ? tx_buf_q : {tx_buf_q[6:0], 1'b0};
						cnt_q <= 4'h0;
						st_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (!enabled_q) begin
						st_q <= ST_IDLE;
					end else if (sck_rise) begin
						if (lsb_first) begin
							sh_q <= {pin_s2_q[PIN_SI], sh_q[7:1]};
						end else begin
							sh_q <= {sh_q[6:0], pin_s2_q[PIN_SI]};
						end
						cnt_q <= cnt_q + 4'h1;
						if (last_bit) begin
							done_q <= 1'b1;
							st_q <= ST_WAIT;
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// received frame into the data register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_q <= 16'h0000;
		end else if (done_q) begin
			if (lsb_first && nbits == BITS_7) begin
				data_q <= {9'h000, sh_q[7:1]};
			end else if (nbits == BITS_7) begin
				data_q <= {9'h000, sh_q[6:0]};
			end else begin
				data_q <= {8'h00, sh_q};
			end
		end
	end

	// buffer-empty event when the engine takes the buffer
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			empty_ev_q <= 1'b0;
		end else begin
			empty_ev_q <= take_buf;
		end
	end

	// sticky irq flag; a set in the same cycle beats a software clear
	logic irq_set, irq_clr;
	assign irq_set = mode_q[MODE_IRQ_SRC_BIT] ? empty_ev_q : done_q;
	assign irq_clr = wr && i_avl.address == REG_IRQ_FLAGS && !i_avl.writedata[IRQ_FLAG_BIT];
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_flag_q <= 1'b0;
		end else if (irq_set) begin
			irq_flag_q <= 1'b1;
		end else if (irq_clr) begin
			irq_flag_q <= 1'b0;
		end
	end

	// overrun: a frame ends while the previous one was never read
	logic unread_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			unread_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			if (done_q) begin
				unread_q <= 1'b1;
			end else if (rd && data_view(i_avl.address)) begin
				unread_q <= 1'b0;
			end
			if (done_q && unread_q) begin
				overrun_q <= 1'b1;
			end else if (wr && i_avl.address == REG_FLAG_CLEAR && i_avl.writedata[OVR_CLEAR_BIT]) begin
				overrun_q <= 1'b0;
			end
		end
	end

	// level interrupt out
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= irq_flag_q && !mask_q[IRQ_FLAG_BIT];
		end
	end

	// read mux
	logic [15:0] stat;
	always_comb begin
		stat = 16'h0000;
		stat[STAT_ACTIVE_BIT] = (st_q == ST_SHIFT);
		stat[STAT_BUF_FULL_BIT] = tx_full_q;
		stat[STAT_OVERRUN_BIT] = overrun_q;
		stat[STAT_ENABLED_BIT] = enabled_q;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_readdata <= 32'h0000_0000;
		end else if (rd) begin
			unique case (i_avl.address)
				REG_MODE: o_readdata <= {16'h0000, mode_q};
				REG_CONFIG: o_readdata <= {16'h0000, config_q};
				REG_DATA: o_readdata <= {16'h0000, data_q};
				REG_BYTE_VIEW: o_readdata <= {24'h000000, data_q[7:0]};
				REG_STATUS: o_readdata <= {16'h0000, stat};
				REG_START: o_readdata <= UNMAPPED_READ;
				REG_OUT_LEVELS: o_readdata <= {16'h0000, levels_q};
				REG_OUT_ENABLES: o_readdata <= {16'h0000, enables_q};
				REG_PORT_LATCH: o_readdata <= {24'h000000, (latch_q & ~dir_q) | (pin_s2_q & dir_q)};
				REG_PORT_DIR: o_readdata <= {24'h000000, dir_q};
				REG_IRQ_FLAGS: o_readdata <= 32'(irq_flag_q) << IRQ_FLAG_BIT;
				REG_IRQ_MASKS: o_readdata <= {24'h000000, mask_q};
				default: o_readdata <= UNMAPPED_READ;
			endcase
		end
	end

	// serial data output value
	logic so_bit;
	always_comb begin
		so_bit = levels_q[CHAN_BIT];
		if (enables_q[CHAN_BIT] && st_q == ST_SHIFT) begin
			so_bit = lsb_first ? sh_q[0] : sh_q[7];
		end
	end

	// pins: latch drives, data output pin carries the serial bit ANDed with its latch bit
	logic [7:0] pin_val;
	always_comb begin
		pin_val = latch_q;
		pin_val[PIN_SO] = latch_q[PIN_SO] & so_bit;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pin <= 8'h00;
			o_pin_oe <= 8'h00;
		end else begin
			o_pin <= pin_val;
			o_pin_oe <= ~dir_q;
		end
	end
endmodule

// ### hw/sync_serial_slave_pkg.sv
// constants, register map and types for the clocked serial slave channel
// What this block does
// - frame length selects 7-bit or 8-bit frame; other codes prohibited here
// - 9-bit length code is never accepted for this clocked channel
// - serial output level bit sets the data output value, 0 low, 1 high; the data output pin gets it ANDed with its port latch bit
// - output enable 1 lets the engine drive data; 0 stops engine output
// - pin direction bit 0 makes output, 1 makes input
// - port latch drives output pins; input pins read back sampled level
// - transfer irq flag reads 1 when request pending; software writes 0 to clear
// - mask bit 0 passes the pending request to interrupt, 1 blocks it
// - start trigger 1 sets channel enabled and waits for communication; 0 ignored
// - start trigger register always reads zero
// - status bit 6 reads 1 while a transfer is in progress
// - writing data low byte loads frame and starts; byte view also given
// - external clock select takes shift clock from serial clock pin as slave
// - bit order 0 shifts msb first, 1 lsb first, both directions
// - irq source 0 raises on transfer end, 1 on transmit buffer empty
// - overrun clear trigger 1 clears overrun flag; 0 leaves it
package sync_serial_slave_pkg;
	localparam int ADDR_W = 4;
	// word indices of the register map
	localparam logic [3:0] REG_MODE = 4'h0;
	localparam logic [3:0] REG_CONFIG = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h2;
	localparam logic [3:0] REG_BYTE_VIEW = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_START = 4'h5;
	localparam logic [3:0] REG_STOP = 4'h6;
	localparam logic [3:0] REG_FLAG_CLEAR = 4'h7;
	localparam logic [3:0] REG_OUT_LEVELS = 4'h8;
	localparam logic [3:0] REG_OUT_ENABLES = 4'h9;
	localparam logic [3:0] REG_PORT_LATCH = 4'ha;
	localparam logic [3:0] REG_PORT_DIR = 4'hb;
	localparam logic [3:0] REG_IRQ_FLAGS = 4'hc;
	localparam logic [3:0] REG_IRQ_MASKS = 4'hd;
	// field positions
	localparam int MODE_CLK_SEL_BIT = 14;
	localparam int MODE_IRQ_SRC_BIT = 0;
	localparam int CFG_TX_EN_BIT = 15;
	localparam int CFG_RX_EN_BIT = 14;
	localparam int CFG_BIT_ORDER_BIT = 7;
	localparam int STAT_ACTIVE_BIT = 6;
	localparam int STAT_BUF_FULL_BIT = 5;
	localparam int STAT_OVERRUN_BIT = 0;
	localparam int STAT_ENABLED_BIT = 8;
	localparam int CHAN_BIT = 0;
	localparam int OVR_CLEAR_BIT = 0;
	localparam int IRQ_FLAG_BIT = 5;
	localparam int PIN_CLK = 0;
	localparam int PIN_SI = 1;
	localparam int PIN_SO = 2;
	// frame length encodings
	localparam logic [1:0] LEN_9BIT = 2'h1;
	localparam logic [1:0] LEN_7BIT = 2'h2;
	localparam logic [1:0] LEN_8BIT = 2'h3;
	localparam logic [3:0] BITS_7 = 4'h7;
	localparam logic [3:0] BITS_8 = 4'h8;
	// reset values
	localparam logic [15:0] MODE_RST = 16'h0020;
	localparam logic [15:0] CONFIG_RST = 16'h0087;
	localparam logic [15:0] OUT_LEVELS_RST = 16'h0f0f;
	localparam logic [15:0] OUT_ENABLES_RST = 16'h0000;
	localparam logic [7:0] PORT_LATCH_RST = 8'h00;
	localparam logic [7:0] PORT_DIR_RST = 8'hff;
	localparam logic [7:0] IRQ_MASK_RST = 8'hff;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// avalon request bundle
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} avl_req_t;
	// channel engine state
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_SHIFT
	} chan_state_t;
endpackage

// ### sim/sync_serial_master.sv
// external serial master model driving the shift clock
`timescale 1ns/10ps
module sync_serial_master (
	// serial lines
	output logic o_sck,
	output logic o_si,
	input wire logic i_so
);
	// clock idles high, still between frames
	initial begin
		o_sck = 1'b1;
		o_si = 1'b1;
	end
	// one pulse per bit, whole frame
	task automatic xfer(input logic [7:0] tx, input int n, input logic lsb, output logic [7:0] rx);
		int k;
		rx = 8'h00;
		for (int i = 0; i < n; i++) begin
			k = lsb ? i : n - 1 - i;
			o_sck = 1'b0;
			o_si = tx[k];
			#80;
			o_sck = 1'b1;
			rx[k] = i_so;
			#80;
		end
		// released line shows no stale copy
		o_si = ~o_si;
	endtask
endmodule

// ### sim/sync_serial_slave_channel_monitor.sv
// assertion checker for the serial slave channel ports
`timescale 1ns/10ps
module sync_serial_slave_channel_monitor
	import sync_serial_slave_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// watched ports
	input wire sync_serial_slave_pkg::avl_req_t i_avl,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	input wire logic [7:0] i_pin,
	input wire logic [7:0] o_pin,
	input wire logic [7:0] o_pin_oe,
	input wire logic o_irq
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	logic rd_ack;
	logic wr_ack;
	logic dir_hit;
	logic latch_hit;
	logic [7:0] wd1_q;
	logic [7:0] wd2_q;
	// accesses completing at this edge
	assign rd_ack = i_avl.read & ~o_waitrequest;
	assign wr_ack = i_avl.write & ~o_waitrequest & i_avl.byteenable[0];
	assign dir_hit = wr_ack && i_avl.address == REG_PORT_DIR;
	assign latch_hit = wr_ack && i_avl.address == REG_PORT_LATCH;
	// write data two edges back; pin writes reach the pins two edges on
	always_ff @(posedge i_clk) begin
		wd1_q <= i_avl.writedata[7:0];
		wd2_q <= wd1_q;
	end
	a_one_wait: assert property ((i_avl.read | i_avl.write) & o_waitrequest |=> !o_waitrequest)
		else $error("access not answered");
	a_ack_single: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("answer held too long");
	a_start_zero: assert property (rd_ack && i_avl.address == REG_START |-> o_readdata == 32'h0)
		else $error("start trigger read not zero");
	a_unmapped_zero: assert property (rd_ack && i_avl.address > REG_IRQ_MASKS |-> o_readdata == UNMAPPED_READ)
		else $error("unmapped read not zero");
	a_dir_to_oe: assert property (dir_hit |=> ##1 o_pin_oe == ~wd2_q)
		else $error("enable not from direction");
	a_latch_to_pin: assert property (latch_hit |=> ##1 ((o_pin ^ wd2_q) & o_pin_oe & 8'hf8) == 8'h00)
		else $error("pin not from latch");
	a_mask_blocks: assert property (wr_ack && i_avl.address == REG_IRQ_MASKS && i_avl.writedata[IRQ_FLAG_BIT] |=> ##1 !o_irq)
		else $error("masked irq still high");
	a_clear_drops: assert property (wr_ack && i_avl.address == REG_IRQ_FLAGS && !i_avl.writedata[IRQ_FLAG_BIT] |=> ##1 !o_irq)
		else $error("cleared irq still high");
	c_irq: cover property ($rose(o_irq));
	c_frame: cover property ($fell(i_pin[PIN_CLK]));
	c_start: cover property (wr_ack && i_avl.address == REG_START);
endmodule
bind sync_serial_slave_channel sync_serial_slave_channel_monitor u_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_avl(i_avl), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_pin(i_pin), .o_pin(o_pin),
	.o_pin_oe(o_pin_oe), .o_irq(o_irq));

// ### sim/test_sync_serial_slave_channel.sv
// self-checking bench for the serial slave channel
`timescale 1ns/10ps
module test_sync_serial_slave_channel;
	import sync_serial_slave_pkg::*;
	logic clk;
	logic rst_n;
	avl_req_t avl;
	logic [31:0] rdata;
	logic wait_req;
	logic [7:0] pin_in;
	logic [7:0] pin;
	logic [7:0] pin_oe;
	logic irq;
	logic sck;
	logic si;
	logic [4:0] ext_hi;
	logic [7:0] rx;
	logic [31:0] q;
	int mismatches = 0;
	int checks_done = 0;
	// wire level: channel where it drives, outside elsewhere
	assign pin_in = (pin & pin_oe) | ({ext_hi, 1'b1, si, sck} & ~pin_oe);
	sync_serial_slave_channel u_sync_serial_slave_channel (.i_clk(clk), .i_rst_n(rst_n), .i_avl(avl),
		.o_readdata(rdata), .o_waitrequest(wait_req), .i_pin(pin_in), .o_pin(pin), .o_pin_oe(pin_oe), .o_irq(irq));
	sync_serial_master u_sync_serial_master (.o_sck(sck), .o_si(si), .i_so(pin_in[PIN_SO]));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one bus access, held until waitrequest is sampled low
	task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		avl <= '{address: a, read: ~w, write: w, byteenable: 4'hf, writedata: d};
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 50);
		q = rdata;
		if (n >= 50) chk(32'h1, 32'h0);
		avl <= '0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		acc(a, 1'b1, d);
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		acc(a, 1'b0, 32'h0);
		chk(q & m, e);
	endtask
	task automatic wirq(input logic e);
		for (int n = 0; n < 20 && irq !== e; n++) begin
			@(posedge clk);
		end
		chk({31'h0, irq}, {31'h0, e});
	endtask
	// frame from the master, busy flag read 30 clocks in
	task automatic frame(input logic [7:0] tx, input int n, input logic lsb, input logic act);
		fork
			u_sync_serial_master.xfer(tx, n, lsb, rx);
			begin
				repeat (30) @(posedge clk);
				rc(REG_STATUS, 32'h40, {25'h0, act, 6'h0});
			end
		join
		@(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, well beyond the expected run
	initial begin
		#100000;
		mismatches++;
		finish_test();
	end
	initial begin
		rst_n = 1'b0;
		avl = '0;
		ext_hi = 5'h15;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc(REG_MODE, 32'hffff, {16'h0, MODE_RST});
		rc(REG_CONFIG, 32'hffff, {16'h0, CONFIG_RST});
		rc(REG_OUT_LEVELS, 32'hffff, {16'h0, OUT_LEVELS_RST});
		rc(REG_OUT_ENABLES, 32'hffff, {16'h0, OUT_ENABLES_RST});
		rc(REG_PORT_DIR, 32'hff, {24'h0, PORT_DIR_RST});
		rc(REG_IRQ_MASKS, 32'hff, {24'h0, IRQ_MASK_RST});
		rc(4'hf, 32'hffffffff, UNMAPPED_READ);
		// pins 7 and 2 out, the rest read back the outside
		wr(REG_PORT_DIR, 32'h7b);
		wr(REG_PORT_LATCH, 32'h84);
		rc(REG_PORT_LATCH, 32'hff, 32'haf);
		chk({24'h0, pin_oe}, 32'h84);
		chk({24'h0, pin & pin_oe}, 32'h84);
		wr(REG_OUT_ENABLES, 32'h1);
		wr(REG_OUT_LEVELS, 32'h0f0e);
		rc(REG_STATUS, 32'h100, 32'h0);
		chk({31'h0, pin[PIN_SO]}, 32'h0);
		wr(REG_OUT_LEVELS, 32'h0f0f);
		wr(REG_MODE, 32'h4000);
		wr(REG_CONFIG, 32'hc003);
		chk({31'h0, pin[PIN_SO]}, 32'h1);
		wr(REG_IRQ_MASKS, 32'h0);
		wr(REG_START, 32'h1);
		rc(REG_START, 32'hffffffff, 32'h0);
		rc(REG_STATUS, 32'h140, 32'h100);
		// full byte, msb first
		wr(REG_DATA, 32'ha5);
		frame(8'h3c, 8, 1'b0, 1'b1);
		chk({24'h0, rx}, 32'ha5);
		wirq(1'b1);
		rc(REG_DATA, 32'hff, 32'h3c);
		rc(REG_STATUS, 32'h40, 32'h0);
		rc(REG_IRQ_FLAGS, 32'h20, 32'h20);
		wr(REG_IRQ_FLAGS, 32'h0);
		wirq(1'b0);
		// seven bits, lsb first, masked then unmasked
		wr(REG_IRQ_MASKS, 32'h20);
		wr(REG_CONFIG, 32'hc082);
		wr(REG_BYTE_VIEW, 32'h35);
		frame(8'h4b, 7, 1'b1, 1'b1);
		chk({24'h0, rx}, 32'h35);
		rc(REG_DATA, 32'h7f, 32'h4b);
		chk({31'h0, irq}, 32'h0);
		wr(REG_IRQ_MASKS, 32'h0);
		wirq(1'b1);
		wr(REG_IRQ_FLAGS, 32'h0);
		wirq(1'b0);
		// nine-bit code must not shift
		wr(REG_CONFIG, 32'hc081);
		wr(REG_DATA, 32'h1ff);
		frame(8'h00, 8, 1'b1, 1'b0);
		rc(REG_IRQ_FLAGS, 32'h20, 32'h0);
		// buffer-empty source; legal length takes the waiting byte at once
		wr(REG_MODE, 32'h4001);
		wr(REG_CONFIG, 32'hc083);
		wirq(1'b1);
		rc(REG_STATUS, 32'h60, 32'h40);
		frame(8'h81, 8, 1'b1, 1'b1);
		chk({24'h0, rx}, 32'hff);
		// engine output stopped: line shows the level bit; second unread frame overruns
		wr(REG_OUT_ENABLES, 32'h0);
		wr(REG_DATA, 32'h0f);
		frame(8'h42, 8, 1'b1, 1'b1);
		chk({24'h0, rx}, 32'hff);
		rc(REG_STATUS, 32'h1, 32'h1);
		wr(REG_FLAG_CLEAR, 32'h1);
		rc(REG_STATUS, 32'h1, 32'h0);
		rc(REG_DATA, 32'hff, 32'h42);
		wr(REG_STOP, 32'h1);
		rc(REG_STATUS, 32'h140, 32'h0);
		finish_test();
	end
endmodule
